// >>> design/ura_phy.sv
// PHY end: command decoder and register array access engine
// Overview of operation
// - Link waits for direction low before commands
// - Command bits 7:6 select idle, transmit, write, read
// - Transmit command carries optional 4-bit packet identifier
// - Immediate access takes address from command bits
// - Low bits 2Fh mean extended address follows
// - Register contents survive low power modes
// - Accept raised after command; data follows
// - Data accepted, accept dropped, Link sends stop
// - Register committed only after stop falls
// - Direction stays low for whole write
// - Link returns bus to idle after write
// - Extended write: address byte, then data byte
// - Immediate read takes bus, drops accept
// - Device drives read data, then returns bus
// - Link drives idle after read turnaround
// - Extended read takes bus after address byte
// - No driving or sampling in turnaround cycle
// - Stop lasts exactly one cycle
// - Everything changes on rising clock edge
// - Direction held high during start-up, while commands impossible
`timescale 1ns/1ps
module ura_phy (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus side
  ura_if.phy bus,
  // Local mode and status
  input wire logic pll_locked,
  input wire logic low_power,
  output logic [3:0] tx_pid,
  output logic tx_start,
  output logic tx_nopid,
  output logic wr_strobe,
  output logic [7:0] wr_addr
);
  import ura_pkg::*;
  typedef enum {S_BOOT, S_IDLE, S_CMD, S_XADDR, S_WDATA, S_WSTOP, S_WCOMMIT,
    S_RTURN, S_RDRV, S_REND} ura_st_t;
  ura_st_t st_reg;
  logic [7:0] cmd_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdat_reg;
  logic [7:0] regs [URA_NREG];
  logic [7:0] rdat_reg;
  logic [3:0] boot_reg;
  logic dir_reg;
  logic nxt_reg;
  logic oe_reg;
  logic tx_reg;
  logic dir_next;
  logic nxt_next;
  logic boot_done;
  logic cmd_seen;

  // Opcode tests, shared by the handshake decode
  function automatic logic op_rd(input logic [7:0] c);
    return c[URA_OP_HI:URA_OP_LO] == URA_OP_RD;
  endfunction
  function automatic logic op_wr(input logic [7:0] c);
    return c[URA_OP_HI:URA_OP_LO] == URA_OP_WR;
  endfunction

  // Phase sequencer; each state is one edge of the documented timing
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= S_BOOT;
      boot_reg <= 4'h0;
      cmd_reg <= 8'h00;
      addr_reg <= 8'h00;
      wdat_reg <= 8'h00;
    end else begin
      case (st_reg)
        S_BOOT: begin
          // Bus held while the clock source settles
          if (pll_locked && boot_reg == 4'(URA_STARTUP_CYC - 1)) begin
            // Bus is in turnaround next cycle, so skip sampling it
            st_reg <= S_REND;
          end else if (pll_locked) begin
            boot_reg <= boot_reg + 4'h1;
          end
        end
        S_IDLE: begin
          if (bus.data != URA_IDLE && !low_power) begin
            cmd_reg <= bus.data;
            addr_reg <= {2'b00, bus.data[5:0]};
            if (bus.data[URA_OP_HI:URA_OP_LO] != URA_OP_XMIT) begin
              st_reg <= S_CMD;
            end
          end
        end
        S_CMD: begin
          // NXT high now; next edge brings address, data or turnaround
          if (ura_is_ext(cmd_reg)) begin
            st_reg <= S_XADDR;
          end else if (cmd_reg[URA_OP_HI:URA_OP_LO] == URA_OP_RD) begin
            st_reg <= S_RTURN;
          end else begin
            st_reg <= S_WDATA;
          end
        end
        S_XADDR: begin
          addr_reg <= bus.data;
          st_reg <= (cmd_reg[URA_OP_HI:URA_OP_LO] == URA_OP_RD) ?
            S_RTURN : S_WDATA;
        end
        S_WDATA: begin
          wdat_reg <= bus.data;
          st_reg <= S_WSTOP;
        end
        S_WSTOP: begin
          // Commit only once the stop pulse has been seen
          st_reg <= bus.stp ? S_WCOMMIT : S_WSTOP;
        end
        S_WCOMMIT: st_reg <= S_IDLE;
        S_RTURN: st_reg <= S_RDRV;
        S_RDRV: st_reg <= S_REND;
        S_REND: st_reg <= S_IDLE;
        default: st_reg <= S_IDLE;
      endcase
    end
  end

  // Register array; no reset so contents survive mode changes
  always_ff @(posedge core_clk) begin
    if (st_reg == S_WCOMMIT && !bus.stp) begin
      regs[addr_reg] <= wdat_reg;
    end
  end

  // Read data fetched one cycle before it is driven
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      rdat_reg <= URA_REG_RST;
    end else if (st_reg == S_RTURN) begin
      rdat_reg <= regs[addr_reg];
    end
  end

  // Handshake levels in state order, before they are registered
  assign boot_done = pll_locked && boot_reg == 4'(URA_STARTUP_CYC - 1);
  assign cmd_seen = st_reg == S_IDLE && bus.data != URA_IDLE && !low_power;

  // Direction: held in boot, raised for turnaround and read data
  always_comb begin
    dir_next = 1'b0;
    case (st_reg)
      S_BOOT: dir_next = !boot_done;
      S_CMD: dir_next = op_rd(cmd_reg) && !ura_is_ext(cmd_reg);
      S_XADDR: dir_next = op_rd(cmd_reg);
      S_RTURN: dir_next = 1'b1;
      default: dir_next = 1'b0;
    endcase
  end

  // Accept: raised once per byte the Link still owes
  always_comb begin
    nxt_next = 1'b0;
    case (st_reg)
      S_IDLE: nxt_next = cmd_seen &&
        bus.data[URA_OP_HI:URA_OP_LO] != URA_OP_XMIT;
      S_CMD: nxt_next = ura_is_ext(cmd_reg) || op_wr(cmd_reg);
      S_XADDR: nxt_next = op_wr(cmd_reg);
      default: nxt_next = 1'b0;
    endcase
  end

  // Handshake outputs, all registered on the rising edge
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      dir_reg <= 1'b1;
      nxt_reg <= 1'b0;
      oe_reg <= 1'b0;
    end else begin
      dir_reg <= dir_next;
      nxt_reg <= nxt_next;
      oe_reg <= st_reg == S_RTURN;
    end
  end

  // Transmit command decode toward the packet path
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      tx_reg <= 1'b0;
      tx_pid <= 4'h0;
      tx_nopid <= 1'b0;
    end else begin
      tx_reg <= st_reg == S_IDLE && !low_power &&
        bus.data[URA_OP_HI:URA_OP_LO] == URA_OP_XMIT;
      // Packet identifier kept for the transmit path to pick up
      if (st_reg == S_IDLE &&
        bus.data[URA_OP_HI:URA_OP_LO] == URA_OP_XMIT) begin
        tx_pid <= bus.data[3:0];
        tx_nopid <= bus.data[5:0] == URA_NOPID;
      end
    end
  end

  assign bus.dir = dir_reg;
  assign bus.nxt = nxt_reg;
  assign bus.phy_doe = oe_reg;
  assign bus.phy_dout = rdat_reg;
  assign tx_start = tx_reg;
  assign wr_strobe = st_reg == S_WCOMMIT && !bus.stp;
  assign wr_addr = addr_reg;
endmodule

// >>> design/ura_pkg.sv
// Package holding the command encodings and register access constants
package ura_pkg;
  localparam int URA_DW = 8;
  localparam int URA_AW = 8;
  localparam int URA_NREG = 256;
  // Command opcode field in bits 7:6
  localparam int URA_OP_HI = 7;
  localparam int URA_OP_LO = 6;
  localparam logic [1:0] URA_OP_IDLE = 2'h0;
  localparam logic [1:0] URA_OP_XMIT = 2'h1;
  localparam logic [1:0] URA_OP_WR = 2'h2;
  localparam logic [1:0] URA_OP_RD = 2'h3;
  localparam logic [5:0] URA_EXT_ADDR = 6'h2F;
  localparam logic [5:0] URA_NOPID = 6'h00;
  localparam logic [7:0] URA_IDLE = 8'h00;
  localparam logic [7:0] URA_REG_RST = 8'h00;
  // Start-up hold of the direction line, in cycles
  localparam int URA_STARTUP_CYC = 8;
  localparam int URA_CLK_MHZ = 60;
  // True for an extended register access command
  function automatic logic ura_is_ext(input logic [7:0] cmd);
    return cmd[5:0] == URA_EXT_ADDR;
  endfunction
endpackage

// >>> design/ura_if.sv
// Interface carrying the 8-bit bus and its three handshake lines
`timescale 1ns/1ps
interface ura_if;
  logic [7:0] link_dout;
  logic link_doe;
  logic [7:0] phy_dout;
  logic phy_doe;
  logic dir;
  logic nxt;
  logic stp;
  logic [7:0] data;
  // Resolved bus level; undriven reads as idle
  assign data = phy_doe ? phy_dout : (link_doe ? link_dout : 8'h00);
  modport phy (input data, input stp, output dir, output nxt,
    output phy_dout, output phy_doe);
  modport link (input data, input dir, input nxt, output stp,
    output link_dout, output link_doe);
endinterface

// >>> design/ura_link.sv
// Link end: issues register writes and reads over the bus
`timescale 1ns/1ps
module ura_link (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus side
  ura_if.link bus,
  // User request
  input wire logic req_valid,
  input wire logic req_write,
  input wire logic [7:0] req_addr,
  input wire logic [7:0] req_wdata,
  output logic req_ready,
  output logic [7:0] rsp_data,
  output logic rsp_valid
);
  import ura_pkg::*;
  typedef enum {L_IDLE, L_CMD, L_ADDR, L_DATA, L_STOP, L_RWAIT, L_RGET,
    L_TURN} ura_lst_t;
  ura_lst_t st_reg;
  logic [7:0] dout_reg;
  logic [7:0] addr_reg;
  logic [7:0] wdat_reg;
  logic wr_reg;
  logic ext_reg;
  logic stp_reg;
  logic oe_reg;
  logic dir_q_reg;

  // Request sequencer
  always_ff @(posedge core_clk or negedge rst_n) begin
    if (!rst_n) begin
      st_reg <= L_IDLE;
      dout_reg <= URA_IDLE;
      addr_reg <= 8'h00;
      wdat_reg <= 8'h00;
      wr_reg <= 1'b0;
      ext_reg <= 1'b0;
      stp_reg <= 1'b0;
      oe_reg <= 1'b0;
      rsp_data <= 8'h00;
      rsp_valid <= 1'b0;
      dir_q_reg <= 1'b1;
    end else begin
      dir_q_reg <= bus.dir;
      rsp_valid <= 1'b0;
      stp_reg <= 1'b0;
      oe_reg <= !bus.dir && !dir_q_reg;
      case (st_reg)
        L_IDLE: begin
          dout_reg <= URA_IDLE;
          if (req_valid && !bus.dir && !dir_q_reg) begin
            ext_reg <= req_addr[7:6] != 2'b00 || req_addr[5:0] == URA_EXT_ADDR;
            addr_reg <= req_addr;
            wdat_reg <= req_wdata;
            wr_reg <= req_write;
            dout_reg <= {req_write ? URA_OP_WR : URA_OP_RD,
              (req_addr[7:6] != 2'b00) ? URA_EXT_ADDR : req_addr[5:0]};
            st_reg <= L_CMD;
          end
        end
        L_CMD: begin
          if (bus.nxt) begin
            if (ext_reg) begin
              dout_reg <= addr_reg;
              st_reg <= L_ADDR;
            end else if (wr_reg) begin
              dout_reg <= wdat_reg;
              st_reg <= L_DATA;
            end else begin
              st_reg <= L_RWAIT;
            end
          end
        end
        L_ADDR: begin
          if (wr_reg) begin
            dout_reg <= wdat_reg;
            st_reg <= L_DATA;
          end else begin
            st_reg <= L_RWAIT;
          end
        end
        L_DATA: begin
          if (!bus.nxt) begin
            dout_reg <= URA_IDLE;
            stp_reg <= 1'b1;
            st_reg <= L_STOP;
          end
        end
        L_STOP: st_reg <= L_IDLE;
        L_RWAIT: begin
          if (bus.dir) begin
            st_reg <= L_RGET;
          end
        end
        L_RGET: begin
          // First cycle of dir high is turnaround; sample after it
          if (dir_q_reg && bus.dir) begin
            rsp_data <= bus.data;
            rsp_valid <= 1'b1;
            dout_reg <= URA_IDLE;
            st_reg <= L_TURN;
          end
        end
        L_TURN: st_reg <= L_IDLE;
        default: st_reg <= L_IDLE;
      endcase
    end
  end

  assign bus.link_dout = dout_reg;
  assign bus.link_doe = oe_reg && !bus.dir;
  assign bus.stp = stp_reg;
  assign req_ready = st_reg == L_IDLE && !bus.dir && !dir_q_reg;
endmodule

// >>> dv/ura_monitor.sv
// Checker of the bus handshake between the two ends
`timescale 1ns/1ps
module ura_monitor (
  // Clock and reset
  input wire logic core_clk,
  input wire logic rst_n,
  // Bus lines
  input wire logic [7:0] data,
  input wire logic link_doe,
  input wire logic phy_doe,
  input wire logic dir,
  input wire logic nxt,
  input wire logic stp
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (!rst_n);
  // Register command right after idle, Link owning the bus
  sequence s_cmd;
    !dir && $past(data) == 8'h00 && data[7];
  endsequence
  // Read turnaround: free cycle, PHY data, then bus handed back
  sequence s_rd_tail;
    !nxt && !phy_doe ##1 dir && phy_doe ##1 !dir && !phy_doe;
  endsequence
  // Write close: accept drops, stop follows for one cycle
  sequence s_wr_close;
    $fell(nxt) ##1 stp ##1 !stp;
  endsequence
  a_no_bus_clash: assert property (!(link_doe && phy_doe))
    else $error("both ends drive the bus");
  a_cmd_gets_nxt: assert property (s_cmd |=> nxt)
    else $error("no accept after command");
  a_wr_dir_low: assert property (s_cmd ##0 !data[6] |-> !dir [*5])
    else $error("direction rose during write");
  a_wr_end: assert property (s_cmd ##0 !data[6] |->
    ##[3:4] s_wr_close)
    else $error("write not closed by stop");
  a_rd_take: assert property (
    s_cmd ##0 data[6] |-> ##[2:3] $rose(dir))
    else $error("read did not take the bus");
  a_rd_tail: assert property ($rose(dir) |-> s_rd_tail)
    else $error("read turnaround wrong");
  a_turn_free: assert property (
    $changed(dir) |-> !phy_doe && !link_doe)
    else $error("bus driven in turnaround");
  a_stp_pulse: assert property ($rose(stp) |=> !stp)
    else $error("stop longer than one cycle");
  a_stp_idle: assert property (
    stp |-> !nxt && !dir && data == 8'h00)
    else $error("stop without idle bus");
endmodule

// >>> dv/tb_top.sv
// Bench joining both ends and running register traffic
`timescale 1ns/1ps
module tb_top;
  logic core_clk = 1'b0;
  logic rst_n = 1'b1;
  logic pll_locked = 1'b0;
  logic req_valid = 1'b0;
  logic req_write = 1'b0;
  logic [7:0] req_addr = 8'h00;
  logic [7:0] req_wdata = 8'h00;
  logic req_ready, rsp_valid, wr_strobe, dir_s;
  logic [7:0] rsp_data, wr_addr;
  int bad_count = 0;
  int checked = 0;
  ura_if bus ();
  assign dir_s = bus.dir;
  ura_phy ura_phy_i (.core_clk(core_clk), .rst_n(rst_n), .bus(bus.phy),
    .pll_locked(pll_locked), .low_power(1'b0), .tx_pid(), .tx_start(),
    .tx_nopid(), .wr_strobe(wr_strobe), .wr_addr(wr_addr));
  ura_link ura_link_i (.core_clk(core_clk), .rst_n(rst_n),
    .bus(bus.link), .req_valid(req_valid), .req_write(req_write),
    .req_addr(req_addr), .req_wdata(req_wdata), .req_ready(req_ready),
    .rsp_data(rsp_data), .rsp_valid(rsp_valid));
  ura_monitor ura_monitor_i (.core_clk(core_clk), .rst_n(rst_n),
    .data(bus.data), .link_doe(bus.link_doe), .phy_doe(bus.phy_doe),
    .dir(bus.dir), .nxt(bus.nxt), .stp(bus.stp));
  // 250 MHz clock
  always #2 core_clk = ~core_clk;
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checked++;
    if (got !== exp) begin
      bad_count++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic print_verdict();
    $display("checks=%0d mismatches=%0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask
  // Bounded wait at falling edges; a hang shows as a mismatch
  task automatic wait_lvl(ref logic f, input logic v);
    int n;
    n = 0;
    while (f !== v && n < 60) begin
      @(negedge core_clk);
      n++;
    end
    chk({7'h00, f}, {7'h00, v});
  endtask
  // Held until taken at a rising edge with ready high
  task automatic issue(input logic wr, input logic [7:0] a, d);
    req_write = wr;
    req_addr = a;
    req_wdata = d;
    req_valid = 1'b1;
    wait_lvl(req_ready, 1'b1);
    @(negedge core_clk);
    req_valid = 1'b0;
  endtask
  task automatic t_write(input logic [7:0] a, d);
    issue(1'b1, a, d);
    wait_lvl(wr_strobe, 1'b1);
    chk(wr_addr, a);
  endtask
  task automatic t_read(input logic [7:0] a, exp);
    issue(1'b0, a, 8'h00);
    wait_lvl(rsp_valid, 1'b1);
    chk(rsp_data, exp);
  endtask
  // Bus held by the PHY until its clock is good
  task automatic t_startup();
    chk({7'h00, dir_s}, 8'h01);
    repeat (3) @(negedge core_clk);
    chk({7'h00, dir_s}, 8'h01);
    pll_locked = 1'b1;
    wait_lvl(dir_s, 1'b0);
  endtask
  // Address carried in the command, 05h and the top of its range, 3Fh
  task automatic t_imm();
    t_write(8'h05, 8'hA5);
    t_read(8'h05, 8'hA5);
    t_write(8'h3F, 8'h5A);
    t_read(8'h3F, 8'h5A);
  endtask
  // Escape address and full 8-bit addresses, back to back
  task automatic t_ext();
    t_write(8'h2F, 8'h3C);
    t_write(8'h40, 8'hC3);
    t_write(8'hFF, 8'h81);
    t_read(8'h2F, 8'h3C);
    t_read(8'hFF, 8'h81);
    t_read(8'h40, 8'hC3);
  endtask
  // Earlier contents survive later traffic
  task automatic t_retain();
    t_read(8'h05, 8'hA5);
    t_read(8'h3F, 8'h5A);
  endtask
  initial begin
    // Falling reset after time zero so every register sees it
    #1 rst_n = 1'b0;
    repeat (6) @(negedge core_clk);
    rst_n = 1'b1;
    t_startup();
    t_imm();
    t_ext();
    t_retain();
    print_verdict();
  end
  // Watchdog far beyond the expected hundred or so cycles
  initial begin
    #40000;
    bad_count++;
    print_verdict();
  end
endmodule
